//--- rtl/cpu_status_flags_unit.sv
/*
  Status flag register of an 8-bit cpu core with branch test, stack
  save/restore ports, displacement adder and an apb window.
  Assumes execute, branch and interrupt logic drive strobes on pclk.
*/
// How it works
// - six condition flags follow latest flag-setting operation
// - carry, overflow, zero, sign feed branch test
// - half and decimal flags never reach branch test
// - user flags change only by explicit write, apb write or interrupt return
// - no branch condition tests user flags
// - user flags have no reset term
// - interrupt, trap, illegal trap push full flags
// - interrupt return reloads all eight flag bits
// - displacement sign-extended before address addition
`timescale 1ns/1ps
module cpu_status_flags_unit
  import flags_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [flags_pkg::addr_width-1:0] paddr,
  input wire logic [flags_pkg::data_width-1:0] pwdata,
  output logic [flags_pkg::data_width-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alu_update,
  input wire logic [5:0] alu_flags_mask,
  input wire logic [5:0] alu_flags_value,
  input wire logic user_write,
  input wire logic [1:0] user_mask_in,
  input wire logic [1:0] user_value,
  input wire logic interrupt_entry,
  input wire logic trap_entry,
  input wire logic illegal_trap,
  input wire logic interrupt_return_instr,
  input wire logic [flags_pkg::flag_width-1:0] stack_flags,
  input wire flags_pkg::cond_sel_type cond_sel,
  input wire logic cond_invert,
  input wire logic [7:0] disp_in,
  input wire logic [15:0] base_addr,
  output logic [flags_pkg::flag_width-1:0] push_data,
  output logic push_valid,
  output logic branch_taken,
  output logic [15:0] target_addr
);
  import flags_pkg::*;

  typedef struct packed {
    logic [5:0] cond;
    logic [7:0] push;
    logic push_v;
    logic taken;
    logic [15:0] target;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } state_type;

  state_type s_q, s_d;
  // user flags live apart from the struct: they have no reset term, so
  // they cannot share the async-reset register with the rest
  logic [1:0] user_q, user_d;
  logic [7:0] flags_now;
  logic save_event;
  logic apb_write;
  logic test_bit;

  // cond holds C Z S V D H in bits 5..0, users in 1..0 of the image
  assign flags_now = {s_q.cond, user_q};
  assign save_event = interrupt_entry | trap_entry | illegal_trap;
  // a write lands only on the access edge where pready is seen high
  assign apb_write = psel && penable && pwrite && s_q.ready &&
                     paddr == off_flags;

  always_comb begin
    s_d = s_q;
    user_d = user_q;
    s_d.ready = 1'b0;
    s_d.err = 1'b0;
    s_d.push_v = 1'b0;
    // priority: restore, then apb write, then alu/explicit writes
    if (alu_update) begin
      s_d.cond = (s_q.cond & ~alu_flags_mask) |
                 (alu_flags_value & alu_flags_mask);
    end
    if (user_write) begin
      user_d = (user_q & ~user_mask_in) |
               (user_value & user_mask_in);
    end
    if (psel && !penable) begin
      s_d.ready = 1'b1;
      s_d.rdata = '0;
      case (paddr)
        off_flags: s_d.rdata[7:0] = flags_now;
        off_disp: s_d.rdata[7:0] = disp_in;
        off_addr: s_d.rdata[15:0] = s_q.target;
        off_status: s_d.rdata[1:0] = {s_q.push_v, s_q.taken};
        default: s_d.err = 1'b1;
      endcase
    end
    // read data is taken in setup, so it shows flags before this write
    if (apb_write) begin
      s_d.cond = pwdata[bit_carry:bit_half] & cond_mask;
      user_d = pwdata[bit_user_one:bit_user_two] & user_mask;
    end
    if (interrupt_return_instr) begin
      s_d.cond = stack_flags[bit_carry:bit_half];
      user_d = stack_flags[bit_user_one:bit_user_two];
    end
    if (save_event) begin
      s_d.push = flags_now;
      s_d.push_v = 1'b1;
    end
    // only C Z S V are selectable; D, H and users have no select
    case (cond_sel)
      cond_always: test_bit = 1'b1;
      cond_carry: test_bit = s_q.cond[bit_carry-bit_half];
      cond_zero: test_bit = s_q.cond[bit_zero-bit_half];
      cond_sign: test_bit = s_q.cond[bit_sign-bit_half];
      cond_overflow: test_bit = s_q.cond[bit_overflow-bit_half];
      default: test_bit = 1'b0;
    endcase
    s_d.taken = test_bit ^ cond_invert;
    s_d.target = base_addr + {{8{disp_in[7]}}, disp_in};
  end

  // user bits sit outside the reset so they keep their value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.cond <= cond_reset;
      s_q.push <= 8'h00;
      s_q.push_v <= 1'b0;
      s_q.taken <= 1'b0;
      s_q.target <= 16'h0000;
      s_q.rdata <= 32'h00000000;
      s_q.ready <= 1'b0;
      s_q.err <= 1'b0;
    end else begin
      s_q.cond <= s_d.cond;
      s_q.push <= s_d.push;
      s_q.push_v <= s_d.push_v;
      s_q.taken <= s_d.taken;
      s_q.target <= s_d.target;
      s_q.rdata <= s_d.rdata;
      s_q.ready <= s_d.ready;
      s_q.err <= s_d.err;
    end
  end

  always_ff @(posedge pclk) begin
    user_q <= user_d;
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign push_data = s_q.push;
  assign push_valid = s_q.push_v;
  assign branch_taken = s_q.taken;
  assign target_addr = s_q.target;

  push_image_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    save_event |=> push_valid && push_data == $past(flags_now))
    else $error("push image wrong");
  push_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !save_event |=> !push_valid)
    else $error("push without event");
  restore_all_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    interrupt_return_instr |=> flags_now == $past(stack_flags))
    else $error("restore wrong");
  user_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !user_write && !interrupt_return_instr && !apb_write |=>
    $stable(user_q))
    else $error("user flag changed");
  user_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_write && !interrupt_return_instr |=>
    user_q == $past(pwdata[bit_user_one:bit_user_two]))
    else $error("user flag write lost");
  cond_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !alu_update && !apb_write && !interrupt_return_instr |=>
    $stable(s_q.cond))
    else $error("condition flags drifted");
  alu_update_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    alu_update && alu_flags_mask == cond_mask && !interrupt_return_instr &&
    !apb_write |=> s_q.cond == $past(alu_flags_value))
    else $error("alu update lost");
  carry_branch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cond_sel == cond_carry && !cond_invert |=>
    branch_taken == $past(flags_now[bit_carry]))
    else $error("carry test wrong");
  zero_branch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cond_sel == cond_zero && cond_invert |=>
    branch_taken == !$past(flags_now[bit_zero]))
    else $error("zero test wrong");
  sign_branch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cond_sel == cond_sign && !cond_invert |=>
    branch_taken == $past(flags_now[bit_sign]))
    else $error("sign test wrong");
  overflow_branch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cond_sel == cond_overflow && !cond_invert |=>
    branch_taken == $past(flags_now[bit_overflow]))
    else $error("overflow test wrong");
  always_branch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cond_sel == cond_always && !cond_invert |=> branch_taken)
    else $error("always not taken");
  never_branch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cond_sel == cond_never && !cond_invert |=> !branch_taken)
    else $error("never taken");
  disp_sext_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> target_addr == 16'($past(base_addr) +
    {{8{$past(disp_in[7])}}, $past(disp_in)}))
    else $error("displacement wrong");
  // a stretched pready would let a master see one access twice
  ready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held too long");
endmodule

//--- rtl/flags_pkg.sv
/*
  Shared constants for the cpu status flag register block.
  Assumes a single pclk domain and an apb master on the same clock.
*/
package flags_pkg;
  localparam int flag_width = 8;
  localparam int data_width = 32;
  localparam int addr_width = 12;
  // bit order, also the stack image order
  localparam int bit_carry = 7;
  localparam int bit_zero = 6;
  localparam int bit_sign = 5;
  localparam int bit_overflow = 4;
  localparam int bit_decimal = 3;
  localparam int bit_half = 2;
  localparam int bit_user_one = 1;
  localparam int bit_user_two = 0;
  localparam logic [5:0] cond_mask = 6'h3f;
  localparam logic [1:0] user_mask = 2'h3;
  localparam logic [5:0] cond_reset = 6'h00;
  // apb word offsets
  localparam logic [11:0] off_flags = 12'h000;
  localparam logic [11:0] off_disp = 12'h004;
  localparam logic [11:0] off_addr = 12'h008;
  localparam logic [11:0] off_status = 12'h00c;
  // branch condition selects
  typedef enum logic [2:0] {
    cond_always = 3'h0,
    cond_carry = 3'h1,
    cond_zero = 3'h2,
    cond_sign = 3'h3,
    cond_overflow = 3'h4,
    cond_never = 3'h5
  } cond_sel_type;
endpackage

//--- verif/cpu_status_flags_unit_tb_top.sv
/*
  Bench for the status flag unit: apb tasks and strobe sequences.
  Assumes flag_stack_model answers the push and restore strobes.
*/
`timescale 1ns/1ps
module cpu_status_flags_unit_tb_top;
  import flags_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, push_valid, branch_taken, err;
  logic alu_update = 0, user_write = 0, cond_invert = 0;
  logic interrupt_entry = 0, trap_entry = 0, illegal_trap = 0;
  logic interrupt_return_instr = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [5:0] alu_flags_mask = '0, alu_flags_value = '0;
  logic [1:0] user_mask_in = '0, user_value = '0;
  logic [7:0] disp_in = '0, stack_flags, push_data;
  logic [15:0] base_addr = '0, target_addr;
  cond_sel_type cond_sel = cond_always;
  int fails = 0, comparisons = 0;
  always #5 pclk = ~pclk;
  cpu_status_flags_unit dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .alu_update,
    .alu_flags_mask, .alu_flags_value, .user_write, .user_mask_in,
    .user_value, .interrupt_entry, .trap_entry, .illegal_trap,
    .interrupt_return_instr, .stack_flags, .cond_sel, .cond_invert,
    .disp_in, .base_addr, .push_data, .push_valid, .branch_taken,
    .target_addr);
  flag_stack_model stack (.pclk, .push_valid, .push_data, .stack_flags);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // waits on pready itself; no fixed latency is assumed
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    // no timeout here; if pready never comes only the watchdog ends this wait
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000 fails++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, off_flags, 32'h000000a7);
    apb(0, off_flags, 0);
    chk(r, 32'ha7);
    @(posedge pclk) presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, off_flags, 0);
    chk(r, 32'h03);
    $display("reset test done");
    @(posedge pclk) {alu_update, alu_flags_mask, alu_flags_value}
      <= {1'b1, 6'h30, 6'h1f};
    @(posedge pclk) {alu_update, user_write, user_mask_in} <= 4'b0110;
    @(posedge pclk) user_write <= 1'b0;
    apb(0, off_flags, 0);
    chk(r, 32'h41);
    $display("flag update test done");
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      {interrupt_entry, trap_entry, illegal_trap} <= 3'b100 >> k;
      @(posedge pclk) {interrupt_entry, trap_entry, illegal_trap} <= '0;
      #1 chk(push_valid, 1);
      chk(push_data, 32'h41);
    end
    @(posedge pclk) {alu_update, alu_flags_mask, alu_flags_value}
      <= {1'b1, 6'h3f, 6'h2a};
    @(posedge pclk) alu_update <= 1'b0;
    // second pass inverts every select, so zero and never flip too
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 6; k++) begin
        @(posedge pclk) cond_sel <= cond_sel_type'(3'(k));
        cond_invert <= i[0];
        @(posedge pclk) #1;
        chk(branch_taken, (6'b001011 >> k & 1) ^ i);
      end
    end
    $display("push and branch test done");
    @(posedge pclk) interrupt_return_instr <= 1'b1;
    @(posedge pclk) {interrupt_return_instr, disp_in, base_addr}
      <= {1'b0, 8'h80, 16'h0100};
    apb(0, off_flags, 0);
    chk(r, 32'h41);
    chk(target_addr, 32'h0080);
    apb(0, off_addr, 0);
    chk(r, 32'h80);
    apb(0, off_disp, 0);
    chk(r, 32'h80);
    apb(0, off_status, 0);
    chk(r, 32'h01);
    apb(0, 12'h010, 0);
    chk({err, r[30:0]}, 32'h80000000);
    $display("restore and address test done");
    print_verdict();
  end
endmodule

//--- verif/flag_stack_model.sv
/*
  Stack side model: keeps the last pushed flag image for restores.
  Assumes push_valid is a one-cycle pulse on pclk.
*/
`timescale 1ns/1ps
module flag_stack_model (
  input wire logic pclk,
  input wire logic push_valid,
  input wire logic [7:0] push_data,
  output logic [7:0] stack_flags
);
  // whole byte kept so a restore returns the user flags too
  // holds no value until the first push; restores come only after one
  always @(posedge pclk) begin
    if (push_valid) begin
      stack_flags <= push_data;
    end
  end
endmodule
